// ==== verilog/fto_capture.sv ====
/*
  fine trigger offset capture: accepts triggers, honours the blocker line,
  counts triggers, and emits an eight-word record header for each record.
  assumes the trigger arrives as four phase samples per clock and that the
  record buffer takes one header word per cycle when hdrReady is high.
*/
`timescale 1ns/1ps
module fto_capture
#(
  parameter int CNT_W = fto_pkg::CNT_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // trigger source
  input wire logic [3:0] trigPhases,
  input wire logic fineEnable,
  // blocker line
  input wire logic blockerPin,
  input wire logic blockerEnable,
  // arming
  input wire logic arm,
  // header sink and status outputs
  input wire logic hdrReady,
  output logic hdrValid,
  output logic [2:0] hdrIndex,
  output logic [31:0] hdrWord,
  output logic armed,
  output logic trigAccepted
);
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HEADER} fto_state_e;

  // ==========================================================
  // edge detection
  logic edgeSeen;
  logic [1:0] edgeCode;
  logic lastPhase;
  logic next_lastPhase;

  fto_phase_encoder u_enc
  (
    .phases(trigPhases),
    .lastPhase(lastPhase),
    .edgeSeen(edgeSeen),
    .offsetCode(edgeCode)
  );

  // ==========================================================
  // state
  fto_state_e state;
  fto_state_e next_state;
  logic [1:0] offset;
  logic [1:0] next_offset;
  logic [CNT_W-1:0] totalCnt;
  logic [CNT_W-1:0] next_totalCnt;
  logic [CNT_W-1:0] acqCnt;
  logic [CNT_W-1:0] next_acqCnt;
  logic [63:0] stamp;
  logic [63:0] next_stamp;
  logic [63:0] trigStamp;
  logic [63:0] next_trigStamp;
  logic [2:0] next_hdrIndex;
  logic [31:0] next_hdrWord;
  logic next_hdrValid;
  logic next_armed;
  logic next_trigAccepted;
  logic blockOk;
  logic accept;

  always_comb
  begin
    blockOk = !blockerEnable || blockerPin;
    accept = (state == ST_ARMED) && edgeSeen && blockOk;
    next_lastPhase = trigPhases[3];
    next_stamp = stamp + 64'h1;
    next_state = state;
    next_offset = offset;
    next_totalCnt = totalCnt;
    next_acqCnt = acqCnt;
    next_trigStamp = trigStamp;
    next_hdrIndex = hdrIndex;
    next_hdrValid = hdrValid;
    next_trigAccepted = accept;
    unique case (state)
      ST_IDLE:
      begin
        if (arm)
        begin
          next_state = ST_ARMED;
          next_acqCnt = '0;
        end
      end
      ST_ARMED:
      begin
        if (accept)
        begin
          next_offset = fineEnable ? edgeCode : fto_pkg::OFS_ZERO;
          next_trigStamp = stamp;
          next_totalCnt = totalCnt + {{(CNT_W-1){1'b0}}, 1'b1};
          next_acqCnt = acqCnt + {{(CNT_W-1){1'b0}}, 1'b1};
          next_state = ST_HEADER;
          next_hdrIndex = '0;
          next_hdrValid = 1'b1;
        end
      end
      ST_HEADER:
      begin
        if (hdrReady)
        begin
          if (hdrIndex == 3'(fto_pkg::HDR_WORDS - 1))
          begin
            next_hdrValid = 1'b0;
            next_state = ST_ARMED;
          end
          else
          begin
            next_hdrIndex = hdrIndex + 3'h1;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_armed = (next_state != ST_IDLE);
  end

  // ==========================================================
  // header word formatting
  always_comb
  begin
    next_hdrWord = 32'h0;
    unique case (next_hdrIndex)
      fto_pkg::HDR_W_TRIGTYPE:
        next_hdrWord[fto_pkg::OFS_MSB:fto_pkg::OFS_LSB] = next_offset;
      fto_pkg::HDR_W_TOTAL:
        next_hdrWord = 32'(next_totalCnt);
      fto_pkg::HDR_W_ACQ:
        next_hdrWord = 32'(next_acqCnt);
      fto_pkg::HDR_W_STAMP_LO:
        next_hdrWord = next_trigStamp[31:0];
      fto_pkg::HDR_W_STAMP_HI:
        next_hdrWord = next_trigStamp[63:32];
      default:
        next_hdrWord = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      lastPhase <= 1'b0;
      offset <= fto_pkg::OFS_ZERO;
      totalCnt <= '0;
      acqCnt <= '0;
      stamp <= 64'h0;
      trigStamp <= 64'h0;
      hdrIndex <= 3'h0;
      hdrWord <= 32'h0;
      hdrValid <= 1'b0;
      armed <= 1'b0;
      trigAccepted <= 1'b0;
    end
    else
    begin
      state <= next_state;
      lastPhase <= next_lastPhase;
      offset <= next_offset;
      totalCnt <= next_totalCnt;
      acqCnt <= next_acqCnt;
      stamp <= next_stamp;
      trigStamp <= next_trigStamp;
      hdrIndex <= next_hdrIndex;
      hdrWord <= next_hdrWord;
      hdrValid <= next_hdrValid;
      armed <= next_armed;
      trigAccepted <= next_trigAccepted;
    end
  end

  // ==========================================================
  // checks
  property p_blocked;
    @(posedge clk) disable iff (reset)
    (blockerEnable && !blockerPin) |=> !trigAccepted;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("trigger accepted while blocked");

  property p_release;
    @(posedge clk) disable iff (reset)
    (state == ST_ARMED && edgeSeen && blockerPin) |=> trigAccepted;
  endproperty
  a_release: assert property (p_release)
    else $error("released trigger not accepted");

  property p_offset_hold;
    @(posedge clk) disable iff (reset)
    (state == ST_HEADER) |=> $stable(offset) || state == ST_ARMED;
  endproperty
  a_offset_hold: assert property (p_offset_hold)
    else $error("offset changed during header");

  property p_offset_latch;
    @(posedge clk) disable iff (reset)
    (accept && fineEnable) |=> offset == $past(edgeCode);
  endproperty
  a_offset_latch: assert property (p_offset_latch)
    else $error("offset not latched on accept");

  property p_word2;
    @(posedge clk) disable iff (reset)
    (hdrValid && hdrIndex == fto_pkg::HDR_W_TRIGTYPE)
      |-> hdrWord[17:16] == offset;
  endproperty
  a_word2: assert property (p_word2)
    else $error("offset missing from header word 2");

  property p_phase1;
    @(posedge clk) disable iff (reset)
    (accept && fineEnable && trigPhases == 4'he) |=> offset == 2'h1;
  endproperty
  a_phase1: assert property (p_phase1)
    else $error("quarter code wrong");

  property p_total;
    @(posedge clk) disable iff (reset)
    accept |=> totalCnt == $past(totalCnt) + 1;
  endproperty
  a_total: assert property (p_total)
    else $error("total count not advanced");

  sequence s_accept;
    accept;
  endsequence
  sequence s_header_start;
    hdrValid && hdrIndex == 3'h0;
  endsequence
  property p_header;
    @(posedge clk) disable iff (reset)
    s_accept |=> s_header_start;
  endproperty
  a_header: assert property (p_header)
    else $error("header not started after accept");

  property p_stamp;
    @(posedge clk) disable iff (reset)
    accept |=> trigStamp == $past(stamp);
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("time stamp not one period resolution");

  property p_oversample;
    @(posedge clk) disable iff (reset)
    (accept && fineEnable && trigPhases == 4'h8) |=> offset == 2'h3;
  endproperty
  a_oversample: assert property (p_oversample)
    else $error("last phase not resolved");
endmodule : fto_capture

// ==== verilog/fto_pkg.sv ====
/*
  constants shared by the fine trigger offset capture block: header word
  layout, offset codes, counter widths and clock figures.
  assumes a trigger clock of 100 MHz and a four-phase oversampled input.
*/
package fto_pkg;
  // ==========================================================
  // oversampling
  localparam int PHASES = 4;
  localparam int PHASE_W = 2;
  // ==========================================================
  // clock figures
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SUB_PERIOD_PS = CLK_PERIOD_PS / PHASES;
  // ==========================================================
  // offset codes, quarters of a clock period
  localparam logic [1:0] OFS_ZERO = 2'h0;
  localparam logic [1:0] OFS_ONE_Q = 2'h1;
  localparam logic [1:0] OFS_TWO_Q = 2'h2;
  localparam logic [1:0] OFS_THREE_Q = 2'h3;
  // ==========================================================
  // header layout
  localparam int HDR_WORDS = 8;
  localparam int HDR_IDX_W = 3;
  localparam logic [2:0] HDR_W_TRIGTYPE = 3'h2;
  localparam logic [2:0] HDR_W_TOTAL = 3'h3;
  localparam logic [2:0] HDR_W_ACQ = 3'h4;
  localparam logic [2:0] HDR_W_STAMP_LO = 3'h6;
  localparam logic [2:0] HDR_W_STAMP_HI = 3'h7;
  localparam int OFS_LSB = 16;
  localparam int OFS_MSB = 17;
  localparam int CNT_W = 32;
  localparam int STAMP_W = 64;
endpackage : fto_pkg

// ==== verilog/fto_phase_encoder.sv ====
/*
  turns four oversampled trigger phases into a first-edge flag and the
  two-bit quarter offset code.
  assumes phase 0 is the earliest sample within one trigger clock cycle.
*/
`timescale 1ns/1ps
module fto_phase_encoder
(
  // oversampled trigger, current and previous cycle
  input wire logic [3:0] phases,
  input wire logic lastPhase,
  // result
  output logic edgeSeen,
  output logic [1:0] offsetCode
);
  // ==========================================================
  // first rising edge among the four phases
  always_comb
  begin
    edgeSeen = 1'b0;
    offsetCode = fto_pkg::OFS_ZERO;
    if (phases[0] && !lastPhase)
    begin
      edgeSeen = 1'b1;
      offsetCode = fto_pkg::OFS_ZERO;
    end
    else if (phases[1] && !phases[0])
    begin
      edgeSeen = 1'b1;
      offsetCode = fto_pkg::OFS_ONE_Q;
    end
    else if (phases[2] && !phases[1])
    begin
      edgeSeen = 1'b1;
      offsetCode = fto_pkg::OFS_TWO_Q;
    end
    else if (phases[3] && !phases[2])
    begin
      edgeSeen = 1'b1;
      offsetCode = fto_pkg::OFS_THREE_Q;
    end
  end
endmodule : fto_phase_encoder

// ==== sim/fto_trig_source.sv ====
/*
  far side model: external trigger source and master blocker line.
  assumes the bench requests triggers after the clock edge.
*/
`timescale 1ns/1ps
module fto_trig_source
(
  // clock
  input wire logic clk,
  // bench requests
  input wire logic fire,
  input wire logic [1:0] firePhase,
  input wire logic releaseLine,
  // lines to device
  output logic [3:0] trigPhases,
  output logic blockerPin
);
  // ==========================================================
  // trigger edge: low, edge at phase p, high, low again
  logic [1:0] step = 2'h0;
  logic [1:0] phaseHeld = 2'h0;
  // master drives the line low until released after arming
  assign blockerPin = releaseLine;
  always_ff @(posedge clk)
  begin
    if (step == 2'h0 && fire)
    begin
      step <= 2'h1;
      phaseHeld <= firePhase;
    end
    else if (step != 2'h0)
    begin
      step <= step + 2'h1;
    end
  end
  assign trigPhases = (step == 2'h1) ? (4'hf << phaseHeld) :
                      (step == 2'h2) ? 4'hf : 4'h0;
endmodule : fto_trig_source

// ==== sim/testbench.sv ====
/*
  self-checking bench for the fine trigger offset capture block.
  assumes the source model in fto_trig_source and a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic fineEnable = 1'b1;
  logic blockerEnable = 1'b1;
  logic arm = 1'b0;
  logic hdrReady = 1'b0;
  logic fire = 1'b0;
  logic [1:0] firePhase = 2'h0;
  logic releaseLine = 1'b0;
  logic [3:0] trigPhases;
  logic blockerPin;
  logic hdrValid;
  logic [2:0] hdrIndex;
  logic [31:0] hdrWord;
  logic armed;
  logic trigAccepted;
  logic [31:0] words [8];
  int nHeaders = 0;
  int nAccepted = 0;
  int cycles = 0;
  int n_errors = 0;
  int comparisons = 0;
  int tick = 0;
  int expStamp = 0;
  fto_capture u_dut (.clk(clk), .reset(reset), .trigPhases(trigPhases),
    .fineEnable(fineEnable), .blockerPin(blockerPin),
    .blockerEnable(blockerEnable), .arm(arm), .hdrReady(hdrReady),
    .hdrValid(hdrValid), .hdrIndex(hdrIndex), .hdrWord(hdrWord),
    .armed(armed), .trigAccepted(trigAccepted));
  fto_trig_source u_src (.clk(clk), .fire(fire), .firePhase(firePhase),
    .releaseLine(releaseLine), .trigPhases(trigPhases),
    .blockerPin(blockerPin));
  // ==========================================================
  // clock, stalling sink, monitors, timeout
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    #1 hdrReady = ~hdrReady;
  end
  always @(posedge clk)
  begin
    cycles++;
    // trigAccepted trails acceptance by one edge, so the stamp is one back
    if (trigAccepted === 1'b1)
    begin
      nAccepted++;
      expStamp = tick - 1;
    end
    if (reset === 1'b1) tick = 0;
    else tick++;
    if (hdrValid === 1'b1 && hdrReady === 1'b1)
    begin
      words[hdrIndex] = hdrWord;
      if (hdrIndex === 3'h7) nHeaders++;
    end
    if (cycles == 3000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : check
  task automatic pulse_arm();
    @(posedge clk);
    #1 arm = 1'b1;
    @(posedge clk);
    #1 arm = 1'b0;
  endtask : pulse_arm
  task automatic fire_at(input logic [1:0] p);
    @(posedge clk);
    #1 fire = 1'b1;
    firePhase = p;
    @(posedge clk);
    #1 fire = 1'b0;
  endtask : fire_at
  task automatic run_record(input logic [1:0] p, input logic [1:0] code,
    input logic [31:0] tot, input logic [31:0] acq);
    int start;
    int acc;
    start = nHeaders;
    acc = nAccepted;
    fire_at(p);
    repeat (60) if (nHeaders == start) @(posedge clk);
    check(nHeaders - start, 1);
    check(nAccepted - acc, 1);
    check(words[2], {14'h0, code, 16'h0});
    check(words[3], tot);
    check(words[4], acq);
    check(words[6], expStamp);
    check(words[0] | words[1] | words[5] | words[7], 32'h0);
  endtask : run_record
  // ==========================================================
  // scenarios
  task automatic t_blocked();
    pulse_arm();
    check(armed, 1'b1);
    fire_at(2'h1);
    repeat (12) @(posedge clk);
    check(nAccepted, 0);
    check(nHeaders, 0);
  endtask : t_blocked
  task automatic t_fine();
    #1 releaseLine = 1'b1;
    for (int p = 0; p < 4; p++)
      run_record(p[1:0], p[1:0], p + 1, p + 1);
  endtask : t_fine
  task automatic t_coarse();
    #1 fineEnable = 1'b0;
    blockerEnable = 1'b0;
    releaseLine = 1'b0;
    run_record(2'h3, 2'h0, 32'h5, 32'h5);
  endtask : t_coarse
  task automatic t_reset_counts();
    @(posedge clk);
    #1 reset = 1'b1;
    fineEnable = 1'b1;
    @(posedge clk);
    #1 reset = 1'b0;
    check(armed, 1'b0);
    pulse_arm();
    check(armed, 1'b1);
    run_record(2'h2, 2'h2, 32'h1, 32'h1);
  endtask : t_reset_counts
  // ==========================================================
  // closing
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    t_blocked();
    t_fine();
    t_coarse();
    t_reset_counts();
    report_and_stop();
  end
endmodule : testbench
